// ==== cbt_bit_timing.sv ====
// cbt_bit_timing: bit-timing registers and bit-period sequencer.
// assumes: classic wishbone master on clk_i; can_rx_i from a pin.
//
// What this block does
// - Both timing registers are reachable only while reset request is set.
// - Register 6 holds jump width in bits 7:6 and prescaler in bits 5:0.
// - A quantum lasts twice the oscillator period times prescaler plus one.
// - Bit timing resynchronises on each recessive-to-dominant bus edge outside the sync quantum.
// - One resynchronisation moves a bit by at most jump width plus one.
// - Register 7 holds triple sample in 7, segment two 6:4, one 3:0.
// - Triple sample takes three samples with majority, else one sample.
// - Segment one lasts its field plus one quanta and places the sample.
// - Segment two lasts its field plus one quanta.
`timescale 1ns/1ps
module cbt_bit_timing
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [5:2] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // can bus
  input  wire logic       can_rx_i,
  // timing outputs
  output logic            quantum_tick_o,
  output logic            sample_point_o,
  output logic            sampled_bit_o,
  output logic            bit_start_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] prescale_jump_ff;
  logic [7:0] segments_ff;
  logic       reset_req_ff;
  logic       req;
  logic       wr;
  logic       lane0;

  assign req   = cyc_i && stb_i && !ack_o;
  // the write lands at the edge where the master sees ack high
  assign wr    = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign lane0 = reset_req_ff; // timing regs gated by reset request

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reset_req_ff <= CBT_RST_RESET_REQ;
    else if (wr && adr_i == CBT_IDX_CONTROL)
      reset_req_ff <= dat_i[CBT_RESET_REQ_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prescale_jump_ff <= CBT_RST_PRESCALE_JUMP;
    else if (wr && lane0 && adr_i == CBT_IDX_PRESCALE_JUMP)
      prescale_jump_ff <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      segments_ff <= CBT_RST_SEGMENTS;
    else if (wr && lane0 && adr_i == CBT_IDX_SEGMENTS)
      segments_ff <= dat_i[7:0];
  end

  // ----------------------------------------------------------------
  // read data; locked timing registers read as zero
  // ----------------------------------------------------------------
  logic [7:0] rd;
  logic       idle;
  logic       busy_ff;

  always_comb
  begin
    rd = 8'h00;
    unique case (adr_i)
      CBT_IDX_CONTROL:       rd = {7'h00, reset_req_ff};
      CBT_IDX_STATUS:        rd = {7'h00, busy_ff};
      CBT_IDX_PRESCALE_JUMP: rd = lane0 ? prescale_jump_ff : 8'h00;
      CBT_IDX_SEGMENTS:      rd = lane0 ? segments_ff : 8'h00;
      default:               rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (req && !we_i)
      dat_o <= {24'h000000, rd};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_ff <= 1'b0;
    else
      busy_ff <= !reset_req_ff;
  end

  assign idle = reset_req_ff;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [5:0] quantum_prescaler;
  logic [1:0] resync_jump_width;
  logic       triple_sample_select;
  logic [3:0] segment_before_sample;
  logic [2:0] segment_after_sample;

  assign quantum_prescaler     = prescale_jump_ff[CBT_PRESCALE_LSB +: 6];
  assign resync_jump_width     = prescale_jump_ff[CBT_JUMP_LSB +: 2];
  assign triple_sample_select  = segments_ff[CBT_TRIPLE_BIT];
  assign segment_before_sample = segments_ff[CBT_SEG1_LSB +: 4];
  assign segment_after_sample  = segments_ff[CBT_SEG2_LSB +: 3];

  // ----------------------------------------------------------------
  // bus input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  logic fall_edge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= can_rx_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  assign fall_edge = rx_prev_ff && !rx_sync_ff;

  // ----------------------------------------------------------------
  // quantum prescaler
  // ----------------------------------------------------------------
  logic tick;

  cbt_prescaler u_prescaler (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (!idle),
    .prescale_i (quantum_prescaler),
    .tick_o     (tick)
  );

  // ----------------------------------------------------------------
  // bit-period sequencer
  // ----------------------------------------------------------------
  cbt_phase_e phase_ff;
  cbt_phase_e nxt_phase;
  logic [7:0] qcnt_ff;
  logic [7:0] nxt_qcnt;
  logic [7:0] seg1_len_ff;
  logic [7:0] nxt_seg1_len;
  logic       edge_seen_ff;
  logic       edge_hit;
  logic [7:0] sjw_len;
  logic [7:0] seg1_len;
  logic [7:0] seg2_len;
  logic       sample_now;
  logic       start_now;

  assign sjw_len  = cbt_len({4'h0, resync_jump_width});
  assign seg1_len = cbt_len({2'b00, segment_before_sample});
  assign seg2_len = cbt_len({3'b000, segment_after_sample});

  // an edge in the tick cycle itself must not be lost to the clear
  assign edge_hit = edge_seen_ff || fall_edge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || idle)
      edge_seen_ff <= 1'b0;
    else if (tick)
      edge_seen_ff <= 1'b0;
    else if (fall_edge)
      edge_seen_ff <= 1'b1;
  end

  // edges are acted on at the next quantum tick; hard sync not modelled
  always_comb
  begin
    nxt_phase    = phase_ff;
    nxt_qcnt     = qcnt_ff;
    nxt_seg1_len = seg1_len_ff;
    sample_now   = 1'b0;
    start_now    = 1'b0;
    if (tick)
    begin
      unique case (phase_ff)
        CBT_SYNC:
        begin
          nxt_phase    = CBT_SEG1;
          nxt_qcnt     = CBT_ONE_QUANTUM;
          nxt_seg1_len = seg1_len;
        end
        CBT_SEG1:
        begin
          if (edge_hit) // late edge lengthens
            nxt_seg1_len = seg1_len
              + ((qcnt_ff < sjw_len) ? qcnt_ff : sjw_len);
          if (qcnt_ff >= nxt_seg1_len)
          begin
            nxt_phase  = CBT_SEG2;
            nxt_qcnt   = CBT_ONE_QUANTUM;
            sample_now = 1'b1;
          end
          else
            nxt_qcnt = qcnt_ff + 8'h01;
        end
        CBT_SEG2:
        begin
          // early edge ends the bit only if that is within jump width
          if (edge_hit && (qcnt_ff + sjw_len > seg2_len))
          begin
            nxt_phase = CBT_SEG1;
            nxt_qcnt  = CBT_ONE_QUANTUM;
            nxt_seg1_len = seg1_len;
            start_now = 1'b1;
          end
          else if (qcnt_ff >= seg2_len)
          begin
            nxt_phase = CBT_SYNC;
            nxt_qcnt  = 8'h00;
            start_now = 1'b1;
          end
          else if (edge_hit) // shorten by jump width only
            nxt_qcnt = qcnt_ff + sjw_len + 8'h01;
          else
            nxt_qcnt = qcnt_ff + 8'h01;
        end
        default:
          nxt_phase = CBT_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || idle)
    begin
      phase_ff    <= CBT_SYNC;
      qcnt_ff     <= 8'h00;
      seg1_len_ff <= 8'h01;
    end
    else
    begin
      phase_ff    <= nxt_phase;
      qcnt_ff     <= nxt_qcnt;
      seg1_len_ff <= nxt_seg1_len;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      quantum_tick_o <= 1'b0;
      sample_point_o <= 1'b0;
      bit_start_o    <= 1'b0;
    end
    else
    begin
      quantum_tick_o <= tick;
      sample_point_o <= sample_now;
      bit_start_o    <= start_now;
    end
  end

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  logic samp_bit;

  cbt_sampler u_sampler (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .sample_i (sample_now),
    .triple_i (triple_sample_select),
    .rx_i     (rx_sync_ff),
    .bit_o    (samp_bit),
    .valid_o  ()
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sampled_bit_o <= 1'b1;
    else
      sampled_bit_o <= samp_bit;
  end

endmodule

// ==== cbt_bit_timing_asserts.sv ====
// port checker for cbt_bit_timing
// assumes: classic wishbone master, one clock, sync reset
`timescale 1ns/1ps
module cbt_bit_timing_asserts
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // can side
  input  wire logic        can_rx_i,
  input  wire logic        quantum_tick_o,
  input  wire logic        sample_point_o,
  input  wire logic        sampled_bit_o,
  input  wire logic        bit_start_o
);
  logic       req_ff;
  logic [5:0] pre_ff;
  logic       seen_ff;
  logic [7:0] gap_ff;
  logic       wr_ack;
  assign wr_ack = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // ----------------------------------------------------------
  // shadow of control and prescaler
  // ----------------------------------------------------------
  always_ff @(posedge clk_i)
    if (rst_i)
      req_ff <= 1'b1;
    else if (wr_ack && adr_i == CBT_IDX_CONTROL)
      req_ff <= dat_i[0];
  always_ff @(posedge clk_i)
    if (rst_i)
      pre_ff <= 6'h00;
    else if (wr_ack && req_ff && adr_i == CBT_IDX_PRESCALE_JUMP)
      pre_ff <= dat_i[5:0];
  // first tick after start has no reference, so it is skipped
  always_ff @(posedge clk_i)
    if (rst_i || req_ff)
      seen_ff <= 1'b0;
    else if (quantum_tick_o)
      seen_ff <= 1'b1;
  always_ff @(posedge clk_i)
    gap_ff <= quantum_tick_o ? 8'h00 : gap_ff + 8'h01;
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_follows: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_rd_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_tick_period: assert property (quantum_tick_o && seen_ff |->
    gap_ff == {1'b0, pre_ff, 1'b1})
    else $error("quantum period wrong");
  a_idle_req: assert property (req_ff && $past(req_ff) &&
    $past(req_ff, 2) |-> !quantum_tick_o && !bit_start_o)
    else $error("timing runs during reset request");
  a_sample_not_end: assert property (sample_point_o |-> !bit_start_o)
    else $error("sample point at bit end");
  a_sampled_rst: assert property ($fell(rst_i) |-> sampled_bit_o)
    else $error("sampled bit not recessive after reset");
endmodule

bind cbt_bit_timing cbt_bit_timing_asserts cbt_bit_timing_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .can_rx_i(can_rx_i),
  .quantum_tick_o(quantum_tick_o), .sample_point_o(sample_point_o),
  .sampled_bit_o(sampled_bit_o), .bit_start_o(bit_start_o));

// ==== cbt_can_node.sv ====
// model of another node on the can line
// assumes: line is recessive high when no node drives it
`timescale 1ns/1ps
module cbt_can_node (
  // clock
  input  wire logic       clk_i,
  // frame control
  input  wire logic       en_i,
  input  wire logic [7:0] pattern_i,
  input  wire logic       change_i,
  // bus line
  output logic            rx_o
);
  logic [2:0] idx_ff;
  // bits change just after the receiver's sample point, so each
  // dominant edge lands early in segment two and forces a resync
  always_ff @(posedge clk_i)
    if (!en_i)
    begin
      idx_ff <= 3'h0;
      rx_o   <= 1'b1;
    end
    else if (change_i)
    begin
      rx_o   <= pattern_i[idx_ff];
      idx_ff <= idx_ff + 3'h1;
    end
endmodule

// ==== cbt_pkg.sv ====
// cbt_pkg: shared constants for the CAN bit-timing block.
// assumes: included before every module of the block.
package cbt_pkg;

  // ----------------------------------------------------------------
  // register map (word index; byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] CBT_IDX_PRESCALE_JUMP = 4'h6;
  localparam logic [3:0] CBT_IDX_SEGMENTS      = 4'h7;
  localparam logic [3:0] CBT_IDX_CONTROL       = 4'h0;
  localparam logic [3:0] CBT_IDX_STATUS        = 4'h1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CBT_JUMP_LSB      = 6;
  localparam int CBT_PRESCALE_LSB  = 0;
  localparam int CBT_TRIPLE_BIT    = 7;
  localparam int CBT_SEG2_LSB      = 4;
  localparam int CBT_SEG1_LSB      = 0;
  localparam int CBT_RESET_REQ_BIT = 0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CBT_RST_PRESCALE_JUMP = 8'h00;
  localparam logic [7:0] CBT_RST_SEGMENTS      = 8'h00;
  localparam logic       CBT_RST_RESET_REQ     = 1'b1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CBT_OSC_PER_QUANTUM_STEP = 2;
  localparam logic [7:0] CBT_ONE_QUANTUM          = 8'h01;

  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_SEG1 = 2'b01,
    CBT_SEG2 = 2'b11
  } cbt_phase_e;

  // length of a field that is stored as value minus one
  function automatic logic [7:0] cbt_len(input logic [5:0] v);
    return {2'b00, v} + 8'h01;
  endfunction

endpackage

// ==== cbt_prescaler.sv ====
// cbt_prescaler: time-quantum tick generator.
// assumes: prescale value is stable while the controller runs.
`timescale 1ns/1ps
module cbt_prescaler
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [5:0] prescale_i,
  // quantum tick
  output logic            tick_o
);

  // ----------------------------------------------------------------
  // quantum = 2 * oscillator period * (prescale + 1)
  // ----------------------------------------------------------------
  logic [6:0] cnt_ff;
  logic [6:0] last;

  assign last = 7'(CBT_OSC_PER_QUANTUM_STEP * (int'(prescale_i) + 1) - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || cnt_ff >= last)
      cnt_ff <= 7'h00;
    else
      cnt_ff <= cnt_ff + 7'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= run_i && cnt_ff >= last;
  end

endmodule

// ==== cbt_sampler.sv ====
// cbt_sampler: single or majority-of-three bus sampling.
// assumes: rx_i already synchronised to clk_i.
`timescale 1ns/1ps
module cbt_sampler
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // sampling
  input  wire logic tick_i,
  input  wire logic sample_i,
  input  wire logic triple_i,
  input  wire logic rx_i,
  // result
  output logic      bit_o,
  output logic      valid_o
);

  // ----------------------------------------------------------------
  // history of the bus level at the last quantum ticks
  // ----------------------------------------------------------------
  logic [1:0] hist_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hist_ff <= 2'b11;
    else if (tick_i)
      hist_ff <= {hist_ff[0], rx_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bit_o <= 1'b1;
    else if (sample_i)
    begin
      if (triple_i)
        bit_o <= (hist_ff[0] & hist_ff[1]) | (hist_ff[0] & rx_i)
               | (hist_ff[1] & rx_i);
      else
        bit_o <= rx_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      valid_o <= 1'b0;
    else
      valid_o <= sample_i;
  end

endmodule

// ==== tb_cbt_bit_timing.sv ====
// testbench for cbt_bit_timing
// assumes: checker bound, can_rx_i driven by cbt_can_node
`timescale 1ns/1ps
module tb_cbt_bit_timing;
  import cbt_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, can_rx_i;
  logic        quantum_tick_o, sample_point_o, sampled_bit_o;
  logic        bit_start_o, node_en;
  logic [5:2]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [7:0]  c6, c7;
  int          error_cnt, cmp_count, cyc_cnt, per, s2, tol;
  cbt_bit_timing cbt_bit_timing_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .can_rx_i(can_rx_i), .quantum_tick_o(quantum_tick_o),
    .sample_point_o(sample_point_o), .sampled_bit_o(sampled_bit_o),
    .bit_start_o(bit_start_o));
  cbt_can_node cbt_can_node_i (.clk_i(clk_i), .en_i(node_en),
    .pattern_i(8'hb2), .change_i(sample_point_o), .rx_o(can_rx_i));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic close_out;
    $display("counts: errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
    adr_i <= a;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(q, {24'h0, e});
  endtask
  // one bit from bit start to bit start; tol 0 asks exact timing
  task automatic one_bit(input int t);
    int n, s;
    logic lvl;
    n = 0;
    s = 0;
    lvl = 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (sample_point_o === 1'b1)
      begin
        s = n;
        lvl = can_rx_i;
      end
    end
    while (bit_start_o !== 1'b1 && n < 2000);
    check(32'(n >= per - t && n <= per + t), 32'h1);
    if (t == 0)
      check(32'(n - s), 32'(s2));
    check(32'(sampled_bit_o), 32'(lvl));
  endtask
  // ----------------------------------------------------------
  // run
  // ----------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, node_en} = 5'b10000;
    {adr_i, sel_i, dat_i} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CBT_IDX_CONTROL, 8'h01);
    rd(CBT_IDX_PRESCALE_JUMP, 8'h00);
    rd(CBT_IDX_SEGMENTS, 8'h00);
    rd(CBT_IDX_STATUS, 8'h00);
    wb(1'b1, 4'hf, 8'hff);
    rd(4'hf, 8'h00);
    $display("register access test done");
    // triple sampling with wide jump, then single with narrow
    for (int k = 0; k < 2; k++)
    begin
      c6 = k == 0 ? 8'hc1 : 8'h02;
      c7 = k == 0 ? 8'ha3 : 8'h10;
      per = 2 * (c6[5:0] + 1);
      s2 = per * (c7[6:4] + 1);
      tol = per * (c6[7:6] + 1);
      per = per * (c7[3:0] + c7[6:4] + 3);
      wb(1'b1, CBT_IDX_CONTROL, 8'h01);
      wb(1'b1, CBT_IDX_PRESCALE_JUMP, c6);
      wb(1'b1, CBT_IDX_SEGMENTS, c7);
      rd(CBT_IDX_PRESCALE_JUMP, c6);
      rd(CBT_IDX_SEGMENTS, c7);
      wb(1'b1, CBT_IDX_CONTROL, 8'h00);
      rd(CBT_IDX_STATUS, 8'h01);
      wb(1'b1, CBT_IDX_PRESCALE_JUMP, 8'hff);
      rd(CBT_IDX_PRESCALE_JUMP, 8'h00);
      one_bit(per);
      repeat (3) one_bit(0);
      node_en <= 1'b1;
      repeat (9) one_bit(tol);
      node_en <= 1'b0;
      $display("test config %0d done", k);
    end
    close_out();
  end
endmodule
